// [core/gpr_pkg.sv]
// constants, register map and bus carrier type for the port C/D/E register block
package gpr_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // width of each port as implemented
  localparam int PC_W = 7;
  localparam int PD_W = 8;
  localparam int PE_W = 4;
  localparam int PIN_W = PC_W + PD_W + PE_W;

  // short I/O instructions see data space shifted down by this amount
  localparam logic [ADDR_W-1:0] IO_OFFSET   = 16'h0020;
  localparam int                IO_ADDR_W   = 6;
  localparam logic [ADDR_W-1:0] EXT_IO_BASE = 16'h0060;

  // data-space offsets
  localparam logic [ADDR_W-1:0] PC_PIN_OFF = 16'h0026;
  localparam logic [ADDR_W-1:0] PD_PIN_OFF = 16'h0029;
  localparam logic [ADDR_W-1:0] PD_DIR_OFF = 16'h002A;
  localparam logic [ADDR_W-1:0] PD_OUT_OFF = 16'h002B;
  localparam logic [ADDR_W-1:0] PE_PIN_OFF = 16'h002C;
  localparam logic [ADDR_W-1:0] PE_DIR_OFF = 16'h002D;
  localparam logic [ADDR_W-1:0] PE_OUT_OFF = 16'h002E;

  // reset values
  localparam logic [PD_W-1:0] PD_OUT_RST = 8'h00;
  localparam logic [PD_W-1:0] PD_DIR_RST = 8'h00;
  localparam logic [PE_W-1:0] PE_OUT_RST = 4'h0;
  localparam logic [PE_W-1:0] PE_DIR_RST = 4'h0;
  localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;

  // one cpu access per cycle: io set means an I/O-instruction address
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic              io;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } gpr_req_t;

endpackage

// [core/gpr_ports.sv]
// register block for general purpose ports C, D and E
// Contract
// R1: registers also decoded at offset minus 0x20
// R2: extended I/O from 0x60 only by data space
// R3: port D out 0x2B, dir 0x2A, pins 0x29
// R4: port E out 0x2E, dir 0x2D, pins 0x2C, 4 bits
// R5: port C pins at 0x26, bits 0-6
// R6: each direction bit sets its pin direction
// R7: virtual-port direction access equals real one
// R8: pin register write toggles, stores nothing
// R9: reset clears port D/E data and direction
// R10: pin registers follow pins, no reset value
// R11: one toggles output bit, zero leaves it
// R12: pin reads synchronised, unimplemented bits zero
`timescale 1ns/1ps
module gpr_ports #(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic                      MCLK_I,
  input  wire logic                      RST_N_I,
  input  wire gpr_pkg::gpr_req_t         BUS_I,
  output logic [gpr_pkg::DATA_W-1:0]     RDATA_O,
  output logic                           RVALID_O,
  input  wire logic [gpr_pkg::PC_W-1:0]  PC_PIN_I,
  output logic [gpr_pkg::PC_W-1:0]       PC_TOGGLE_O,
  input  wire logic [gpr_pkg::PD_W-1:0]  PD_PIN_I,
  output logic [gpr_pkg::PD_W-1:0]       PD_OUT_O,
  output logic [gpr_pkg::PD_W-1:0]       PD_OE_O,
  input  wire logic [gpr_pkg::PE_W-1:0]  PE_PIN_I,
  output logic [gpr_pkg::PE_W-1:0]       PE_OUT_O,
  output logic [gpr_pkg::PE_W-1:0]       PE_OE_O
);

  // reset release synchroniser
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_n;

  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  assign rst_n = rst_sync_ff;

  // pin synchronisers; no reset so the value simply tracks the pins
  logic [gpr_pkg::PIN_W-1:0] pin_raw;
  logic [gpr_pkg::PIN_W-1:0] sync_ff [SYNC_STAGES];
  logic [gpr_pkg::PIN_W-1:0] pin_sync;

  assign pin_raw = {PE_PIN_I, PD_PIN_I, PC_PIN_I};

  always_ff @(posedge MCLK_I)
  begin
    sync_ff[0] <= pin_raw; // R10
  end

  genvar gs;
  generate
    for (gs = 1; gs < SYNC_STAGES; gs++)
    begin : g_sync
      always_ff @(posedge MCLK_I)
      begin
        sync_ff[gs] <= sync_ff[gs-1];
      end
    end
  endgenerate

  assign pin_sync = sync_ff[SYNC_STAGES-1]; // R12

  logic [gpr_pkg::PC_W-1:0] pc_sync;
  logic [gpr_pkg::PD_W-1:0] pd_sync;
  logic [gpr_pkg::PE_W-1:0] pe_sync;

  assign pc_sync = pin_sync[gpr_pkg::PC_W-1:0];
  assign pd_sync = pin_sync[gpr_pkg::PC_W+gpr_pkg::PD_W-1:gpr_pkg::PC_W];
  assign pe_sync = pin_sync[gpr_pkg::PIN_W-1:gpr_pkg::PC_W+gpr_pkg::PD_W];

  // address decode
  logic [gpr_pkg::ADDR_W-1:0] eff_addr;
  logic                       addr_ok;

  function automatic logic hit(input logic [gpr_pkg::ADDR_W-1:0] a,
                               input logic                       ok,
                               input logic [gpr_pkg::ADDR_W-1:0] off);
    hit = ok && (a == off);
  endfunction

  always_comb
  begin
    if (BUS_I.io)
    begin
      // an I/O address is six bits; anything wider cannot reach extended space
      addr_ok  = (BUS_I.addr[gpr_pkg::ADDR_W-1:gpr_pkg::IO_ADDR_W] == '0); // R2
      eff_addr = BUS_I.addr + gpr_pkg::IO_OFFSET; // R1
    end
    else
    begin
      addr_ok  = 1'b1;
      eff_addr = BUS_I.addr;
    end
  end

  logic wr_pd_pin;
  logic wr_pd_dir;
  logic wr_pd_out;
  logic wr_pe_pin;
  logic wr_pe_dir;
  logic wr_pe_out;
  logic wr_pc_pin;

  assign wr_pc_pin = BUS_I.wr && hit(eff_addr, addr_ok, gpr_pkg::PC_PIN_OFF); // R5
  assign wr_pd_pin = BUS_I.wr && hit(eff_addr, addr_ok, gpr_pkg::PD_PIN_OFF); // R3
  assign wr_pd_dir = BUS_I.wr && hit(eff_addr, addr_ok, gpr_pkg::PD_DIR_OFF); // R3
  assign wr_pd_out = BUS_I.wr && hit(eff_addr, addr_ok, gpr_pkg::PD_OUT_OFF); // R3
  assign wr_pe_pin = BUS_I.wr && hit(eff_addr, addr_ok, gpr_pkg::PE_PIN_OFF); // R4
  assign wr_pe_dir = BUS_I.wr && hit(eff_addr, addr_ok, gpr_pkg::PE_DIR_OFF); // R4
  assign wr_pe_out = BUS_I.wr && hit(eff_addr, addr_ok, gpr_pkg::PE_OUT_OFF); // R4

  // port registers
  logic [gpr_pkg::PD_W-1:0] pd_out_ff;
  logic [gpr_pkg::PD_W-1:0] pd_dir_ff;
  logic [gpr_pkg::PE_W-1:0] pe_out_ff;
  logic [gpr_pkg::PE_W-1:0] pe_dir_ff;
  logic [gpr_pkg::PC_W-1:0] pc_tog_ff;
  logic [gpr_pkg::PD_W-1:0] nxt_pd_out;
  logic [gpr_pkg::PD_W-1:0] nxt_pd_dir;
  logic [gpr_pkg::PE_W-1:0] nxt_pe_out;
  logic [gpr_pkg::PE_W-1:0] nxt_pe_dir;
  logic [gpr_pkg::PC_W-1:0] nxt_pc_tog;

  always_comb
  begin
    nxt_pd_out = pd_out_ff;
    nxt_pd_dir = pd_dir_ff;
    nxt_pe_out = pe_out_ff;
    nxt_pe_dir = pe_dir_ff;
    nxt_pc_tog = '0;
    if (wr_pd_out)
      nxt_pd_out = BUS_I.wdata;
    else if (wr_pd_pin)
      nxt_pd_out = pd_out_ff ^ BUS_I.wdata; // R8 R11
    if (wr_pd_dir)
      nxt_pd_dir = BUS_I.wdata; // R7
    if (wr_pe_out)
      nxt_pe_out = BUS_I.wdata[gpr_pkg::PE_W-1:0];
    else if (wr_pe_pin)
      nxt_pe_out = pe_out_ff ^ BUS_I.wdata[gpr_pkg::PE_W-1:0]; // R8 R11
    if (wr_pe_dir)
      nxt_pe_dir = BUS_I.wdata[gpr_pkg::PE_W-1:0]; // R7
    // port C data lives elsewhere; hand it the toggle mask as a pulse
    if (wr_pc_pin)
      nxt_pc_tog = BUS_I.wdata[gpr_pkg::PC_W-1:0]; // R8 R11
  end

  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pd_out_ff <= gpr_pkg::PD_OUT_RST; // R9
      pd_dir_ff <= gpr_pkg::PD_DIR_RST; // R9
      pe_out_ff <= gpr_pkg::PE_OUT_RST; // R9
      pe_dir_ff <= gpr_pkg::PE_DIR_RST; // R9
      pc_tog_ff <= '0;
    end
    else
    begin
      pd_out_ff <= nxt_pd_out;
      pd_dir_ff <= nxt_pd_dir;
      pe_out_ff <= nxt_pe_out;
      pe_dir_ff <= nxt_pe_dir;
      pc_tog_ff <= nxt_pc_tog;
    end
  end

  // read path: one cycle latency, unmapped addresses read zero
  logic [gpr_pkg::DATA_W-1:0] rdata_ff;
  logic                       rvalid_ff;
  logic [gpr_pkg::DATA_W-1:0] nxt_rdata;
  logic                       nxt_rvalid;

  always_comb
  begin
    nxt_rvalid = BUS_I.rd;
    nxt_rdata  = '0;
    if (!BUS_I.rd)
      nxt_rdata = '0;
    else if (hit(eff_addr, addr_ok, gpr_pkg::PC_PIN_OFF))
      nxt_rdata = {1'b0, pc_sync}; // R5 R12
    else if (hit(eff_addr, addr_ok, gpr_pkg::PD_PIN_OFF))
      nxt_rdata = pd_sync; // R12
    else if (hit(eff_addr, addr_ok, gpr_pkg::PD_DIR_OFF))
      nxt_rdata = pd_dir_ff;
    else if (hit(eff_addr, addr_ok, gpr_pkg::PD_OUT_OFF))
      nxt_rdata = pd_out_ff;
    else if (hit(eff_addr, addr_ok, gpr_pkg::PE_PIN_OFF))
      nxt_rdata = {4'h0, pe_sync}; // R4 R12
    else if (hit(eff_addr, addr_ok, gpr_pkg::PE_DIR_OFF))
      nxt_rdata = {4'h0, pe_dir_ff}; // R4
    else if (hit(eff_addr, addr_ok, gpr_pkg::PE_OUT_OFF))
      nxt_rdata = {4'h0, pe_out_ff}; // R4
  end

  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_ff  <= gpr_pkg::RDATA_RST;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign RDATA_O     = rdata_ff;
  assign RVALID_O    = rvalid_ff;
  assign PC_TOGGLE_O = pc_tog_ff;
  assign PD_OUT_O    = pd_out_ff;
  assign PD_OE_O     = pd_dir_ff; // R6
  assign PE_OUT_O    = pe_out_ff;
  assign PE_OE_O     = pe_dir_ff; // R6

  // checks
  logic rst_n_q;

  always_ff @(posedge MCLK_I)
  begin
    rst_n_q <= rst_n;
  end

  property p_io_alias;
    @(posedge MCLK_I) disable iff (!rst_n)
    (BUS_I.wr && BUS_I.io && BUS_I.addr == 16'h000B)
      |=> (PD_OUT_O == $past(BUS_I.wdata));
  endproperty
  a_io_alias: assert property (p_io_alias) else $error("io write to 0x0B missed port D data"); // R1

  property p_ext_io;
    @(posedge MCLK_I) disable iff (!rst_n)
    (BUS_I.io && BUS_I.addr >= 16'h0040)
      |=> ($stable(PD_OUT_O) && $stable(PD_OE_O) && $stable(PE_OUT_O) && $stable(PE_OE_O));
  endproperty
  a_ext_io: assert property (p_ext_io) else $error("wide io address changed a register"); // R2

  property p_pd_dir_map;
    @(posedge MCLK_I) disable iff (!rst_n)
    (BUS_I.wr && !BUS_I.io && BUS_I.addr == 16'h002A)
      |=> (PD_OE_O == $past(BUS_I.wdata)) ##1 (PD_OE_O == $past(PD_OE_O) || $past(BUS_I.wr));
  endproperty
  a_pd_dir_map: assert property (p_pd_dir_map) else $error("port D direction not at 0x2A"); // R3

  property p_pe_read;
    @(posedge MCLK_I) disable iff (!rst_n)
    (BUS_I.rd && !BUS_I.io && BUS_I.addr == 16'h002E)
      |=> (RVALID_O && RDATA_O == {4'h0, $past(PE_OUT_O)});
  endproperty
  a_pe_read: assert property (p_pe_read) else $error("port E data read wrong"); // R4

  property p_pc_read;
    @(posedge MCLK_I) disable iff (!rst_n)
    (BUS_I.rd && BUS_I.io && BUS_I.addr == 16'h0006)
      |=> (RDATA_O[7] == 1'b0 && RDATA_O[6:0] == $past(pc_sync));
  endproperty
  a_pc_read: assert property (p_pc_read) else $error("port C pin read wrong"); // R5

  property p_dir_io;
    @(posedge MCLK_I) disable iff (!rst_n)
    (BUS_I.wr && BUS_I.io && BUS_I.addr == 16'h000D)
      |=> (PE_OE_O == $past(BUS_I.wdata[3:0]));
  endproperty
  a_dir_io: assert property (p_dir_io) else $error("port E direction alias failed"); // R7

  property p_pin_nostore;
    @(posedge MCLK_I) disable iff (!rst_n)
    (BUS_I.wr && !BUS_I.io && BUS_I.addr == 16'h0029)
      |=> ($stable(PD_OE_O) && PD_OUT_O == ($past(PD_OUT_O) ^ $past(BUS_I.wdata)));
  endproperty
  a_pin_nostore: assert property (p_pin_nostore) else $error("pin write did not toggle"); // R8 R11

  property p_pc_toggle;
    @(posedge MCLK_I) disable iff (!rst_n)
    (BUS_I.wr && !BUS_I.io && BUS_I.addr == 16'h0026)
      |=> (PC_TOGGLE_O == $past(BUS_I.wdata[6:0])) ##1 (PC_TOGGLE_O == '0 || $past(BUS_I.wr));
  endproperty
  a_pc_toggle: assert property (p_pc_toggle) else $error("port C toggle pulse wrong"); // R8

  property p_reset_clear;
    @(posedge MCLK_I)
    (rst_n && !rst_n_q)
      |-> (PD_OUT_O == 8'h00 && PD_OE_O == 8'h00 && PE_OUT_O == 4'h0 && PE_OE_O == 4'h0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("ports not cleared by reset"); // R9

  property p_pd_pin_read;
    @(posedge MCLK_I) disable iff (!rst_n)
    (BUS_I.rd && !BUS_I.io && BUS_I.addr == 16'h0029)
      |=> (RDATA_O == $past(pd_sync));
  endproperty
  a_pd_pin_read: assert property (p_pd_pin_read) else $error("port D pin read wrong"); // R10 R12

  property p_cov_toggle;
    @(posedge MCLK_I) disable iff (!rst_n)
    wr_pd_pin ##1 wr_pd_pin;
  endproperty
  c_cov_toggle: cover property (p_cov_toggle);

  property p_cov_io_read;
    @(posedge MCLK_I) disable iff (!rst_n)
    BUS_I.rd && BUS_I.io && addr_ok;
  endproperty
  c_cov_io_read: cover property (p_cov_io_read);

  property p_cov_dir_out;
    @(posedge MCLK_I) disable iff (!rst_n)
    wr_pe_dir ##1 wr_pe_out;
  endproperty
  c_cov_dir_out: cover property (p_cov_dir_out);

endmodule

// [dv/gpr_cpu_model.sv]
// cpu-side model issuing one byte access at a time
`timescale 1ns/1ps
module gpr_cpu_model (
  input  wire logic                       clk_i,
  input  wire logic                       rvalid_i,
  input  wire logic [gpr_pkg::DATA_W-1:0] rdata_i,
  output gpr_pkg::gpr_req_t               bus_o
);
  initial bus_o = '0;

  // drive after a falling edge, taken at the next rising edge
  task automatic access(input logic wr, input logic io, input logic [15:0] addr,
                        input logic [7:0] wdata, output logic [7:0] rdata,
                        output logic rvalid);
    @(negedge clk_i);
    bus_o = '{rd: !wr, wr: wr, io: io, addr: addr, wdata: wdata};
    @(negedge clk_i);
    rvalid = rvalid_i;
    rdata = rdata_i;
    // released bus must not keep showing the last address or data
    bus_o = '{rd: 1'b0, wr: 1'b0, io: !io, addr: ~addr, wdata: ~wdata};
  endtask
endmodule

// [dv/testbench.sv]
// self-checking bench for the port C/D/E register block
`timescale 1ns/1ps
module testbench;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  gpr_pkg::gpr_req_t bus;
  logic [7:0]        rdata;
  logic [7:0]        rd_got;
  logic              rvalid;
  logic              rv_got;
  logic [6:0]        pc_pin = 7'h00;
  logic [6:0]        pc_tgl;
  logic [7:0]        pd_pin = 8'h00;
  logic [7:0]        pd_out;
  logic [7:0]        pd_oe;
  logic [3:0]        pe_pin = 4'h0;
  logic [3:0]        pe_out;
  logic [3:0]        pe_oe;
  int                miscompares = 0;
  int                compares = 0;
  int                cycles = 0;

  always #2.5 clk = ~clk;

  gpr_ports u_gpr_ports (.MCLK_I(clk), .RST_N_I(rst_n), .BUS_I(bus), .RDATA_O(rdata),
    .RVALID_O(rvalid), .PC_PIN_I(pc_pin), .PC_TOGGLE_O(pc_tgl), .PD_PIN_I(pd_pin),
    .PD_OUT_O(pd_out), .PD_OE_O(pd_oe), .PE_PIN_I(pe_pin), .PE_OUT_O(pe_out),
    .PE_OE_O(pe_oe));

  gpr_cpu_model u_gpr_cpu_model (.clk_i(clk), .rvalid_i(rvalid), .rdata_i(rdata),
    .bus_o(bus));

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [15:0] adr(input logic io, input logic [15:0] off);
    return io ? off - gpr_pkg::IO_OFFSET : off;
  endfunction

  task automatic wr(input logic io, input logic [15:0] off, input logic [7:0] d);
    u_gpr_cpu_model.access(1'b1, io, adr(io, off), d, rd_got, rv_got);
    chk("rvalid_on_write", 8'h00, {7'h00, rv_got});
  endtask

  task automatic rd(input logic io, input logic [15:0] off, input logic [7:0] exp);
    u_gpr_cpu_model.access(1'b0, io, adr(io, off), 8'h00, rd_got, rv_got);
    chk("rvalid_on_read", 8'h01, {7'h00, rv_got});
    chk("read_data", exp, rd_got);
  endtask

  task automatic test_reset;
    chk("pd_out", 8'h00, pd_out);
    chk("pd_oe", 8'h00, pd_oe);
    chk("pe_out_oe", 8'h00, {pe_out, pe_oe});
    rd(1'b0, 16'h002B, 8'h00);
    rd(1'b1, 16'h002D, 8'h00);
  endtask

  // write through one alias, read back through the other
  task automatic test_regs;
    logic [15:0] offs [4] = '{16'h002A, 16'h002B, 16'h002D, 16'h002E};
    logic [7:0]  v;
    logic [7:0]  e;
    for (int i = 0; i < 8; i++)
    begin
      v = 8'hA5 ^ 8'(i * 51);
      e = (i >= 4) ? (v & 8'h0F) : v;
      wr(i[0], offs[i / 2], v);
      rd(!i[0], offs[i / 2], e);
      case (i / 2)
        0: chk("pd_oe", e, pd_oe);
        1: chk("pd_out", e, pd_out);
        2: chk("pe_oe", e, {4'h0, pe_oe});
        default: chk("pe_out", e, {4'h0, pe_out});
      endcase
    end
  endtask

  task automatic test_pins;
    pc_pin = 7'h55;
    pd_pin = 8'hC3;
    pe_pin = 4'hA;
    repeat (3) @(negedge clk);
    rd(1'b0, 16'h0026, 8'h55);
    rd(1'b1, 16'h0026, 8'h55);
    rd(1'b1, 16'h0029, 8'hC3);
    rd(1'b0, 16'h002C, 8'h0A);
  endtask

  task automatic test_toggle;
    wr(1'b0, 16'h002B, 8'hA5);
    wr(1'b0, 16'h0029, 8'h0F);
    chk("pd_out_toggled", 8'hAA, pd_out);
    rd(1'b0, 16'h0029, 8'hC3);
    wr(1'b0, 16'h002E, 8'h03);
    wr(1'b1, 16'h002C, 8'hF5);
    chk("pe_out_toggled", 8'h06, {4'h0, pe_out});
    wr(1'b1, 16'h0026, 8'hFF);
    chk("pc_toggle", 8'h7F, {1'b0, pc_tgl});
    @(negedge clk);
    chk("pc_toggle_end", 8'h00, {1'b0, pc_tgl});
    // data-space form of the same pulse; bit 7 is not implemented
    wr(1'b0, 16'h0026, 8'h81);
    chk("pc_toggle_ds", 8'h01, {1'b0, pc_tgl});
  endtask

  // short i/o form cannot reach beyond 0x3F
  task automatic test_refused;
    u_gpr_cpu_model.access(1'b1, 1'b1, 16'h004B, 8'h00, rd_got, rv_got);
    chk("pd_out_kept", 8'hAA, pd_out);
    rd(1'b0, gpr_pkg::EXT_IO_BASE, 8'h00);
    // io 0x49 would alias port D pins if only six bits were decoded
    rd(1'b1, 16'h0069, 8'h00);
  endtask

  // second reset in mid-run must clear what earlier writes left behind
  task automatic test_reset_mid;
    rst_n = 1'b0;
    @(negedge clk);
    chk("pd_out_in_reset", 8'h00, pd_out);
    chk("pd_oe_in_reset", 8'h00, pd_oe);
    chk("pe_in_reset", 8'h00, {pe_out, pe_oe});
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    test_reset();
    rd(1'b0, 16'h002C, 8'h0A);
  endtask

  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      summarize();
    end
  end

  initial
  begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    test_reset();
    test_regs();
    test_pins();
    test_toggle();
    test_refused();
    test_reset_mid();
    summarize();
  end
endmodule
